// ==== common/pswc_params.svh ====
// pswc_params.svh: offsets, command field values, reset values and timing counts
// assumes a 50 MHz system clock
`ifndef PSWC_PARAMS_SVH
`define PSWC_PARAMS_SVH
// ==========
// register byte offsets
`define PSWC_OFF_WAKE_LEVEL 8'h00
`define PSWC_OFF_WAKE_EN 8'h04
`define PSWC_OFF_XTAL_IND 8'h08
`define PSWC_OFF_LP_DIR 8'h0c
`define PSWC_OFF_LP_OUT 8'h10
`define PSWC_OFF_LP_DS 8'h14
`define PSWC_OFF_LP_PE 8'h18
`define PSWC_OFF_PWR_CMD 8'h1c
`define PSWC_OFF_PWR_STAT 8'h20
`define PSWC_BASE_ADDR 32'h40200000
// ==========
// reset values
`define PSWC_RST_WAKE_LEVEL 5'h00
`define PSWC_RST_WAKE_EN 5'h07
`define PSWC_RST_XTAL_IND 1'h0
`define PSWC_RST_LP_DIR 3'h7
`define PSWC_RST_LP_OUT 3'h0
`define PSWC_RST_LP_DS 3'h0
`define PSWC_RST_LP_PE 3'h7
// ==========
// command field values
`define PSWC_CMD_SLEEP 2'h1
`define PSWC_CMD_STANDBY 2'h2
// ==========
// timing
`define PSWC_CLK_MHZ 50
`define PSWC_WAKE_TIME_US 200
`define PSWC_WAKE_CYCLES (`PSWC_WAKE_TIME_US * `PSWC_CLK_MHZ)
`define PSWC_XTAL_CYCLES_DEF 1000
`endif

// ==== common/pswc_pkg.sv ====
// pswc_pkg.sv: types of the power-state and wake-up controller
// assumes pswc_params.svh is on the include path
package pswc_pkg;
	// ==========
	// power states
	typedef enum logic [2:0] {
		PSWC_PREACTIVE,
		PSWC_ACTIVE,
		PSWC_SLEEP,
		PSWC_STANDBY,
		PSWC_WAKING
	} pswc_state_t;

	// ==========
	// analog control bundle
	typedef struct packed {
		logic fast_rc_oscillator_on;
		logic crystal_oscillator_on;
		logic slow_osc_on;
		logic main_supplies_on;
		logic retention_on;
		logic fast_clk_from_crystal;
	} pswc_pwr_t;

	// ==========
	// low-power pin bundle
	typedef struct packed {
		logic [2:0] out;
		logic [2:0] oe;
		logic [2:0] drive_high;
		logic [2:0] pull_en;
	} pswc_pins_t;

	// ==========
	// AHB address phase capture
	typedef struct packed {
		logic active;
		logic write;
		logic [7:0] addr;
	} pswc_ahb_t;

	// ==========
	// module state apart from the wake pin synchroniser
	typedef struct packed {
		pswc_ahb_t ahb;
		logic [31:0] hrdata;
		logic [4:0] wake_level_select;
		logic [4:0] wake_pin_enable;
		logic crystal_high_freq_flag;
		logic [2:0] lowpower_pin_direction;
		logic [2:0] lowpower_pin_output_value;
		logic [2:0] lowpower_pin_drive_strength;
		logic [2:0] lowpower_pin_pull_enable;
		pswc_state_t state;
		logic [1:0] req;
		logic [15:0] cnt;
		logic [4:0] wake_cause;
		pswc_pwr_t pwr;
		pswc_pins_t pins;
	} pswc_regs_t;
endpackage

// ==== verilog/pswc_top.sv ====
// pswc_top.sv: power-state controller with its system-control registers on AHB-Lite
// assumes one 50 MHz clock, wake pins asynchronous, radio timer event on clk
//
// How it works
// R1 - power-on reset enters preactive state
// R2 - preactive uses fast RC and slow RC
// R3 - active uses crystal, fast RC off
// R4 - standby: retention only, slow off, pin wake
// R5 - sleep: retention, slow on, pin or timer
// R6 - wake level bit per pin, 1 high
// R7 - wake enable per pin, reset 0x7
// R8 - three pins may drive outputs when low-power
// R9 - pull setting applies regardless of direction
// R10 - drive strength register, resets zero
// R11 - output value register drives output pins
// R12 - wake-enabled pins ignore direction, keep pull
// R13 - first three pins pulled up by default
// R14 - far side drives pins three and four
// R15 - far side biases pins opposite wake level
// R16 - wake completes within 200 microseconds
// R17 - RAM retention never switched off
// R18 - registers at 0x00..0x18, 4-byte steps
// R19 - crystal flag bit 0, 1 = 32 MHz
// R20 - direction bit 0 output, 1 input
// R21 - drive bit 0 low, 1 high
// R22 - pull bit 1 enabled, 0 disabled
// R23 - wake passes preactive, then active on crystal
// R24 - software requests low-power entry, pins applied
//
// Chosen here: the AHB-Lite interface to the registers.
`include "pswc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module pswc_top
	import pswc_pkg::*;
#(
	parameter int XTAL_CYCLES = `PSWC_XTAL_CYCLES_DEF,
	parameter int WAKE_CYCLES = `PSWC_WAKE_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// wake sources and crystal ready
	input wire logic [4:0] wake_pin_in,
	input wire logic radio_timer_event,
	input wire logic crystal_ready,
	// power and clock control
	output pswc_pwr_t pwr,
	output logic [2:0] state_code,
	// low-power pin pads
	output pswc_pins_t lp_pins
);
	// ==========
	// wake pin synchroniser
	logic [4:0] wk_meta_q;
	logic [4:0] wk_sync_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wk_meta_q <= 5'h1f;
			wk_sync_q <= 5'h1f;
		end else begin
			wk_meta_q <= wake_pin_in;
			wk_sync_q <= wk_meta_q;
		end
	end

	// ==========
	// state
	pswc_regs_t r_q;
	pswc_regs_t r_d;
	logic [4:0] pin_hit;
	logic [2:0] dir_eff;
	logic [31:0] rd_word;

	// a pin fires when enabled and its level matches the selected one
	assign pin_hit = r_q.wake_pin_enable & ~(wk_sync_q ^ r_q.wake_level_select); // R6 R7
	// wake sources are inputs whatever the direction register says
	assign dir_eff = r_q.lowpower_pin_direction | r_q.wake_pin_enable[2:0]; // R12 R20

	always_comb begin
		rd_word = 32'h00000000;
		if (r_q.ahb.addr == `PSWC_OFF_WAKE_LEVEL) begin // R18
			rd_word[4:0] = r_q.wake_level_select;
		end else if (r_q.ahb.addr == `PSWC_OFF_WAKE_EN) begin
			rd_word[4:0] = r_q.wake_pin_enable;
		end else if (r_q.ahb.addr == `PSWC_OFF_XTAL_IND) begin
			rd_word[0] = r_q.crystal_high_freq_flag; // R19
		end else if (r_q.ahb.addr == `PSWC_OFF_LP_DIR) begin
			rd_word[2:0] = r_q.lowpower_pin_direction;
		end else if (r_q.ahb.addr == `PSWC_OFF_LP_OUT) begin
			rd_word[2:0] = r_q.lowpower_pin_output_value;
		end else if (r_q.ahb.addr == `PSWC_OFF_LP_DS) begin
			rd_word[2:0] = r_q.lowpower_pin_drive_strength;
		end else if (r_q.ahb.addr == `PSWC_OFF_LP_PE) begin
			rd_word[2:0] = r_q.lowpower_pin_pull_enable;
		end else if (r_q.ahb.addr == `PSWC_OFF_PWR_CMD) begin
			rd_word[1:0] = r_q.req;
		end else if (r_q.ahb.addr == `PSWC_OFF_PWR_STAT) begin
			rd_word[2:0] = r_q.state;
			rd_word[12:8] = r_q.wake_cause;
		end
	end

	always_comb begin
		r_d = r_q;
		// ==========
		// ahb-lite: zero wait states, reads answered in the data phase
		if (r_q.ahb.active && r_q.ahb.write) begin
			if (r_q.ahb.addr == `PSWC_OFF_WAKE_LEVEL) begin
				r_d.wake_level_select = hwdata[4:0]; // R6
			end else if (r_q.ahb.addr == `PSWC_OFF_WAKE_EN) begin
				r_d.wake_pin_enable = hwdata[4:0]; // R7
			end else if (r_q.ahb.addr == `PSWC_OFF_XTAL_IND) begin
				r_d.crystal_high_freq_flag = hwdata[0]; // R19
			end else if (r_q.ahb.addr == `PSWC_OFF_LP_DIR) begin
				r_d.lowpower_pin_direction = hwdata[2:0]; // R8
			end else if (r_q.ahb.addr == `PSWC_OFF_LP_OUT) begin
				r_d.lowpower_pin_output_value = hwdata[2:0]; // R11
			end else if (r_q.ahb.addr == `PSWC_OFF_LP_DS) begin
				r_d.lowpower_pin_drive_strength = hwdata[2:0]; // R10
			end else if (r_q.ahb.addr == `PSWC_OFF_LP_PE) begin
				r_d.lowpower_pin_pull_enable = hwdata[2:0]; // R9
			end else if (r_q.ahb.addr == `PSWC_OFF_PWR_CMD) begin
				r_d.req = hwdata[1:0]; // R24
			end
		end
		r_d.ahb.active = hsel && hready && htrans[1];
		r_d.ahb.write = hwrite;
		r_d.ahb.addr = haddr[7:0];
		r_d.hrdata = 32'h00000000;
		if (hsel && hready && htrans[1] && !hwrite) begin
			r_d.ahb.addr = haddr[7:0];
		end
		// ==========
		// power state machine
		case (r_q.state)
			PSWC_PREACTIVE: begin
				if (crystal_ready) begin
					r_d.state = PSWC_ACTIVE; // R23
				end
			end
			PSWC_ACTIVE: begin
				if (r_q.req == `PSWC_CMD_SLEEP) begin
					r_d.state = PSWC_SLEEP; // R24
					r_d.req = 2'h0;
				end else if (r_q.req == `PSWC_CMD_STANDBY) begin
					r_d.state = PSWC_STANDBY; // R24
					r_d.req = 2'h0;
				end
			end
			PSWC_SLEEP: begin
				if ((|pin_hit) || radio_timer_event) begin // R5
					r_d.state = PSWC_WAKING;
					r_d.wake_cause = pin_hit;
					r_d.cnt = 16'h0000;
				end
			end
			PSWC_STANDBY: begin
				if (|pin_hit) begin // R4
					r_d.state = PSWC_WAKING;
					r_d.wake_cause = pin_hit;
					r_d.cnt = 16'h0000;
				end
			end
			PSWC_WAKING: begin
				// supplies restored, counted out before preactive
				r_d.cnt = r_q.cnt + 16'h0001;
				if (r_q.cnt >= 16'(XTAL_CYCLES - 1) || r_q.cnt >= 16'(WAKE_CYCLES - 1)) begin // R16
					r_d.state = PSWC_PREACTIVE; // R23
				end
			end
			default: begin
				r_d.state = PSWC_PREACTIVE;
			end
		endcase
		// ==========
		// clock and supply outputs
		r_d.pwr.retention_on = 1'b1; // R17
		r_d.pwr.fast_rc_oscillator_on = (r_d.state == PSWC_PREACTIVE) ||
			(r_d.state == PSWC_WAKING); // R2 R3
		r_d.pwr.crystal_oscillator_on = (r_d.state == PSWC_ACTIVE); // R3
		r_d.pwr.fast_clk_from_crystal = (r_d.state == PSWC_ACTIVE); // R3
		r_d.pwr.slow_osc_on = (r_d.state != PSWC_STANDBY); // R2 R4 R5
		r_d.pwr.main_supplies_on = (r_d.state != PSWC_SLEEP) &&
			(r_d.state != PSWC_STANDBY); // R4 R5
		// ==========
		// low-power pad drive, only in sleep and standby, aligned with the state; pulls apply in every state
		if ((r_d.state == PSWC_SLEEP) || (r_d.state == PSWC_STANDBY)) begin
			r_d.pins.oe = ~dir_eff; // R8 R12 R20
			r_d.pins.out = r_q.lowpower_pin_output_value & ~dir_eff; // R11
			r_d.pins.drive_high = r_q.lowpower_pin_drive_strength; // R10 R21
		end else begin
			r_d.pins.oe = 3'h0;
			r_d.pins.out = 3'h0;
			r_d.pins.drive_high = 3'h0;
		end
		r_d.pins.pull_en = r_q.lowpower_pin_pull_enable; // R9 R13 R22
		// ==========
		// read data lands in the data phase
		if (hsel && hready && htrans[1] && !hwrite) begin
			r_d.hrdata = 32'h00000000;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r_q <= '0;
			r_q.wake_level_select <= `PSWC_RST_WAKE_LEVEL;
			r_q.wake_pin_enable <= `PSWC_RST_WAKE_EN; // R7
			r_q.crystal_high_freq_flag <= `PSWC_RST_XTAL_IND;
			r_q.lowpower_pin_direction <= `PSWC_RST_LP_DIR; // R8
			r_q.lowpower_pin_output_value <= `PSWC_RST_LP_OUT;
			r_q.lowpower_pin_drive_strength <= `PSWC_RST_LP_DS; // R10
			r_q.lowpower_pin_pull_enable <= `PSWC_RST_LP_PE; // R9 R13
			r_q.state <= PSWC_PREACTIVE; // R1
			r_q.pwr <= 6'b101110;
			r_q.pins.pull_en <= `PSWC_RST_LP_PE;
		end else begin
			r_q <= r_d;
		end
	end

	// ==========
	// outputs
	always_comb begin
		hrdata = rd_word;
	end
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign pwr = r_q.pwr;
	assign state_code = r_q.state;
	assign lp_pins = r_q.pins;

	// ==========
	// assertions
	AST_RESET_PREACTIVE: assert property (@(posedge clk) $rose(resetn) |-> r_q.state == PSWC_PREACTIVE) // R1
		else $error("not preactive after reset");
	AST_RETENTION: assert property (@(posedge clk) disable iff (!resetn) pwr.retention_on) // R17
		else $error("retention dropped");
	AST_ACTIVE_CLK: assert property (@(posedge clk) disable iff (!resetn)
		r_q.state == PSWC_ACTIVE |=> pwr.fast_clk_from_crystal || r_q.state != PSWC_ACTIVE) // R3
		else $error("active not on crystal");
	AST_STANDBY_SLOW: assert property (@(posedge clk) disable iff (!resetn)
		$rose(r_q.state == PSWC_STANDBY) |=> !pwr.slow_osc_on || r_q.state != PSWC_STANDBY) // R4
		else $error("slow oscillator on in standby");
	AST_SLEEP_TIMER: assert property (@(posedge clk) disable iff (!resetn)
		r_q.state == PSWC_SLEEP && radio_timer_event |=> r_q.state == PSWC_WAKING) // R5
		else $error("timer did not wake sleep");
	AST_STANDBY_PIN: assert property (@(posedge clk) disable iff (!resetn)
		r_q.state == PSWC_STANDBY && |pin_hit |=> r_q.state == PSWC_WAKING) // R4 R6 R7
		else $error("pin did not wake standby");
	AST_WAKE_TIME: assert property (@(posedge clk) disable iff (!resetn)
		$rose(r_q.state == PSWC_WAKING) |-> ##[1:1000] r_q.state == PSWC_PREACTIVE) // R16 R23
		else $error("wake too slow");
	AST_PULL_KEPT: assert property (@(posedge clk) disable iff (!resetn)
		##1 lp_pins.pull_en == $past(r_q.lowpower_pin_pull_enable)) // R9 R22
		else $error("pull setting lost");
	AST_WAKE_DIR: assert property (@(posedge clk) disable iff (!resetn)
		(lp_pins.oe & $past(r_q.wake_pin_enable[2:0])) == 3'h0) // R12
		else $error("wake pin driven");
	COV_SLEEP: cover property (@(posedge clk) r_q.state == PSWC_SLEEP);
	COV_STANDBY_WAKE: cover property (@(posedge clk) r_q.state == PSWC_STANDBY ##1 r_q.state == PSWC_WAKING);
	COV_BACK_ACTIVE: cover property (@(posedge clk) r_q.state == PSWC_PREACTIVE ##1 r_q.state == PSWC_ACTIVE);
endmodule // pswc_top
`default_nettype wire

// ==== verification/pswc_pads.sv ====
// pswc_pads.sv: wake pin drivers and pads seen from outside the controller
// assumes lp_pins from pswc_top and drive requests from the bench
`timescale 1ns/1ps
`default_nettype none
module pswc_pads
	import pswc_pkg::*;
(
	// controller pad side
	input wire logic clk,
	input wire pswc_pins_t lp_pins,
	// external drivers
	input wire logic [4:0] drv_en,
	input wire logic [4:0] drv_val,
	output logic [4:0] pin
);
	logic flip = 1'h0;
	always @(posedge clk) flip <= ~flip;
	// ====
	// pad resolution, undriven pins without a pull wander
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			if (drv_en[i]) pin[i] = drv_val[i];
			else if (i < 3 && lp_pins.oe[i]) pin[i] = lp_pins.out[i];
			else if (i < 3 && lp_pins.pull_en[i]) pin[i] = 1'h1;
			else pin[i] = flip;
		end
	end
endmodule // pswc_pads
`default_nettype wire

// ==== verification/pswc_top_tb.sv ====
// pswc_top_tb.sv: random and corner tests of the power-state controller
// assumes pswc_top and pswc_pads, short wake counts
`include "pswc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pswc_top_tb;
	import pswc_pkg::*;
	localparam int WC = 8;
	logic clk = 1'h0, resetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic radio_timer_event = 1'h0, crystal_ready = 1'h0, hreadyout, hresp;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, lv, en, d, o, s, pe;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0, state_code, oe;
	logic [4:0] wake_pin_in, drv_en = 5'h1f, drv_val = 5'h0;
	logic [7:0] off;
	pswc_pwr_t pwr;
	pswc_pins_t lp_pins;
	int miscompares = 0, comparisons = 0, p, sb;
	pswc_top #(.XTAL_CYCLES(WC), .WAKE_CYCLES(WC)) i_pswc_top (.clk(clk), .resetn(resetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .wake_pin_in(wake_pin_in), .radio_timer_event(radio_timer_event),
		.crystal_ready(crystal_ready), .pwr(pwr), .state_code(state_code), .lp_pins(lp_pins));
	pswc_pads i_pswc_pads (.clk(clk), .lp_pins(lp_pins), .drv_en(drv_en), .drv_val(drv_val),
		.pin(wake_pin_in));
	initial forever #10 clk = ~clk;
	// ====
	// expectations
	function automatic logic [31:0] mask(input logic [7:0] a);
		case (a)
			8'h00, 8'h04: mask = 32'h1f;
			8'h08: mask = 32'h1;
			8'h0c, 8'h10, 8'h14, 8'h18: mask = 32'h7;
			default: mask = 32'h0;
		endcase
	endfunction
	function automatic logic [31:0] pw(input int st);
		pw = (st == 0) ? 32'h2e : (st == 1) ? 32'h1f : (st == 2) ? 32'h0a : 32'h02;
	endfunction
	// ====
	// checking and bus tasks
	task conclude;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wst(input logic [2:0] st, input int lim);
		int n;
		n = 0;
		while (state_code !== st && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk({29'h0, state_code}, {29'h0, st});
		if (state_code !== st) conclude();
	endtask
	task rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'h1 && n < 16);
		if (hreadyout !== 1'h1) begin
			miscompares++;
			conclude();
		end
	endtask
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
		hsel <= 1'h1;
		haddr <= `PSWC_BASE_ADDR + {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		rdy();
		r = hrdata;
	endtask
	// ====
	// main sequence
	initial begin
		void'($urandom(19099));
		repeat (2) @(posedge clk);
		resetn <= 1'h1;
		@(posedge clk);
		chk({29'h0, state_code}, 32'h0);
		chk({26'h0, pwr}, pw(0));
		chk({20'h0, lp_pins}, 32'h7);
		for (int i = 0; i < 8; i++) begin
			off = (i == 7) ? 8'h24 : 8'(i * 4);
			ahb(1'h0, off, 32'h0, rd);
			chk(rd, (i == 1 || i == 3 || i == 6) ? 32'h7 : 32'h0);
		end
		repeat (3) for (int i = 0; i < 8; i++) begin
			off = (i == 7) ? 8'h24 : 8'(i * 4);
			d = $urandom;
			ahb(1'h1, off, d, rd);
			ahb(1'h0, off, 32'h0, rd);
			chk(rd, d & mask(off));
		end
		crystal_ready <= 1'h1;
		wst(3'h1, 8);
		chk({26'h0, pwr}, pw(1));
		for (int k = 0; k < 10; k++) begin
			p = k % 5;
			sb = (k >= 5) ? 1 : 0;
			lv = $urandom;
			en = 32'h1 << p;
			d = $urandom;
			o = $urandom;
			s = $urandom;
			pe = $urandom;
			drv_val <= ~lv[4:0];
			ahb(1'h1, 8'h00, lv, rd);
			ahb(1'h1, 8'h04, en, rd);
			ahb(1'h1, 8'h0c, d, rd);
			ahb(1'h1, 8'h10, o, rd);
			ahb(1'h1, 8'h14, s, rd);
			ahb(1'h1, 8'h18, pe, rd);
			ahb(1'h1, 8'h1c, sb ? 32'h2 : 32'h1, rd);
			wst(sb ? 3'h3 : 3'h2, 4);
			chk({26'h0, pwr}, pw(sb ? 3 : 2));
			oe = ~d[2:0] & ~en[2:0];
			chk({lp_pins.out & oe, oe, lp_pins.drive_high, lp_pins.pull_en},
				{o[2:0] & oe, oe, s[2:0], pe[2:0]});
			drv_val[(p + 1) % 5] <= lv[(p + 1) % 5];
			if (sb) radio_timer_event <= 1'h1;
			@(posedge clk);
			radio_timer_event <= 1'h0;
			repeat (6) @(posedge clk);
			chk({29'h0, state_code}, sb ? 32'h3 : 32'h2);
			if (k == 4) radio_timer_event <= 1'h1;
			else drv_val[p] <= lv[p];
			@(posedge clk);
			radio_timer_event <= 1'h0;
			wst(3'h4, 8);
			ahb(1'h0, 8'h20, 32'h0, rd);
			chk(rd, {19'h0, (k == 4) ? 5'h0 : en[4:0], 8'h04});
			wst(3'h0, WC + 4);
			wst(3'h1, 4);
			chk({26'h0, pwr}, pw(1));
		end
		conclude();
	end
endmodule // pswc_top_tb
`default_nettype wire
